// [verilog/phy_ctl_pkg.sv]
package phy_ctl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map and control word layout
   localparam int         REG_W          = 16;
   localparam logic [4:0] REG_CTRL       = 5'h00;
   localparam logic [4:0] REG_LAST_STD   = 5'h05;
   localparam logic [4:0] REG_EXT_A      = 5'h1D;
   localparam logic [4:0] REG_EXT_B      = 5'h1F;
   localparam logic [15:0] CTRL_RESET_VAL = 16'h3120;

   localparam int B_SOFT_RESET  = 15;
   localparam int B_LOOPBACK    = 14;
   localparam int B_SPEED_100   = 13;
   localparam int B_NEG_ENABLE  = 12;
   localparam int B_POWER_DOWN  = 11;
   localparam int B_ISOLATE     = 10;
   localparam int B_NEG_RESTART = 9;
   localparam int B_FULL_DUPLEX = 8;
   localparam int B_XALG_SELECT = 5;
   localparam int B_STRAIGHT    = 4;
   localparam int B_XDET_OFF    = 3;
   localparam int B_FAR_OFF     = 2;
   localparam int B_TX_OFF      = 1;
   localparam int B_LED_OFF     = 0;

   ////////////////////////////////////////////////////////////////////////////
   // serial management frame
   localparam int         PREAMBLE_BITS = 32;
   localparam int         HDR_BITS      = 12;
   localparam int         TA_BITS       = 2;
   localparam int         DATA_BITS     = 16;
   localparam logic [1:0] MDIO_OP_RD    = 2'b10;
   localparam logic [1:0] MDIO_OP_WR    = 2'b01;

   ////////////////////////////////////////////////////////////////////////////
   // spi frame: command byte, address byte {port, reg}, data word
   localparam int         SPI_HDR_BITS = 16;
   localparam int         SPI_FRAME    = 32;
   localparam logic [7:0] SPI_CMD_WR   = 8'h02;
   localparam logic [7:0] SPI_CMD_RD   = 8'h03;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic mac_loopback;
      logic speed_100;
      logic negotiation_enable;
      logic power_down;
      logic transceiver_isolation;
      logic full_duplex;
      logic crossover_algorithm_select;
      logic straight_pair_force;
      logic crossover_detect_off;
      logic far_fault_detect_off;
      logic transmit_off;
      logic led_off;
      logic pair_force_straight;
      logic pair_force_crossed;
   } phy_ctrl_t;

   typedef struct packed {
      phy_ctrl_t ctrl;
      logic      soft_reset;
      logic      restart;
   } ctrl_state_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] port;
      logic [4:0] addr;
      logic [15:0] data;
   } reg_wr_t;

   typedef enum logic [2:0] {MS_IDLE, MS_START, MS_HDR, MS_TA_RD, MS_DATA_RD, MS_TA_WR, MS_DATA_WR,
                             MS_SKIP} mdio_state_t;

   typedef struct packed {
      logic        mdc_s1, mdc_s2, mdc_s3, mdi_s1, mdi_s2;
      logic        sck_s1, sck_s2, sck_s3, cs_s1, cs_s2, mosi_s1, mosi_s2;
      mdio_state_t ms;
      logic [5:0]  pre_cnt;
      logic [4:0]  bit_cnt;
      logic [11:0] hdr;
      logic [15:0] rdata;
      logic [15:0] wdata;
      logic        mdio_out;
      logic        mdio_oe;
      logic [5:0]  spi_cnt;
      logic [15:0] spi_hdr;
      logic [15:0] spi_wr;
      logic [15:0] spi_rd;
      logic        spi_miso;
      logic        spi_oe;
      reg_wr_t     wr;
   } mgmt_state_t;

   // decode of a written control word
   function automatic phy_ctrl_t word_to_ctrl(logic [15:0] d);
      phy_ctrl_t c;
      c.mac_loopback               = d[B_LOOPBACK];
      c.speed_100                  = d[B_SPEED_100];
      c.negotiation_enable         = d[B_NEG_ENABLE];
      c.power_down                 = d[B_POWER_DOWN];
      c.transceiver_isolation      = d[B_ISOLATE];
      c.full_duplex                = d[B_FULL_DUPLEX];
      c.crossover_algorithm_select = d[B_XALG_SELECT];
      c.straight_pair_force        = d[B_STRAIGHT];
      c.crossover_detect_off       = d[B_XDET_OFF];
      c.far_fault_detect_off       = d[B_FAR_OFF];
      c.transmit_off               = d[B_TX_OFF];
      c.led_off                    = d[B_LED_OFF];
      c.pair_force_straight        = d[B_XDET_OFF] & d[B_STRAIGHT];
      c.pair_force_crossed         = d[B_XDET_OFF] & ~d[B_STRAIGHT];
      return c;
   endfunction

   // register addresses answered by the port
   function automatic logic reg_supported(logic [4:0] a);
      return (a <= REG_LAST_STD) || (a == REG_EXT_A) || (a == REG_EXT_B);
   endfunction

endpackage

// [verilog/phy_ctrl_reg.sv]
module phy_ctrl_reg (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   // write strobe
   input  wire logic                   wr_en,
   input  wire logic [15:0]            wr_data,
   // control state
   output phy_ctl_pkg::phy_ctrl_t      ctrl,
   output logic [15:0]                 readback,
   output logic                        soft_reset,
   output logic                        restart
);

   localparam phy_ctl_pkg::ctrl_state_t ST_RESET = '{ctrl: phy_ctl_pkg::word_to_ctrl(phy_ctl_pkg::CTRL_RESET_VAL),
                                                     soft_reset: 1'b0, restart: 1'b0};

   phy_ctl_pkg::ctrl_state_t st_ff;
   phy_ctl_pkg::ctrl_state_t nxt_st;

   ////////////////////////////////////////////////////////////////////////////
   // write decode: soft reset reloads defaults, restart is a pulse
   always_comb begin
      nxt_st            = st_ff;
      nxt_st.soft_reset = 1'b0;
      nxt_st.restart    = 1'b0;
      if (wr_en) begin
         if (wr_data[phy_ctl_pkg::B_SOFT_RESET]) begin
            nxt_st = ST_RESET;
            nxt_st.soft_reset = 1'b1;
         end else begin
            nxt_st.ctrl    = phy_ctl_pkg::word_to_ctrl(wr_data);
            nxt_st.restart = wr_data[phy_ctl_pkg::B_NEG_RESTART];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_ff <= ST_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign ctrl       = st_ff.ctrl;
   assign soft_reset = st_ff.soft_reset;
   assign restart    = st_ff.restart;

   // readback word; self-clearing bits and reserved bits read zero
   always_comb begin
      readback                             = '0;
      readback[phy_ctl_pkg::B_LOOPBACK]    = st_ff.ctrl.mac_loopback;
      readback[phy_ctl_pkg::B_SPEED_100]   = st_ff.ctrl.speed_100;
      readback[phy_ctl_pkg::B_NEG_ENABLE]  = st_ff.ctrl.negotiation_enable;
      readback[phy_ctl_pkg::B_POWER_DOWN]  = st_ff.ctrl.power_down;
      readback[phy_ctl_pkg::B_ISOLATE]     = st_ff.ctrl.transceiver_isolation;
      readback[phy_ctl_pkg::B_FULL_DUPLEX] = st_ff.ctrl.full_duplex;
      readback[phy_ctl_pkg::B_XALG_SELECT] = st_ff.ctrl.crossover_algorithm_select;
      readback[phy_ctl_pkg::B_STRAIGHT]    = st_ff.ctrl.straight_pair_force;
      readback[phy_ctl_pkg::B_XDET_OFF]    = st_ff.ctrl.crossover_detect_off;
      readback[phy_ctl_pkg::B_FAR_OFF]     = st_ff.ctrl.far_fault_detect_off;
      readback[phy_ctl_pkg::B_TX_OFF]      = st_ff.ctrl.transmit_off;
      readback[phy_ctl_pkg::B_LED_OFF]     = st_ff.ctrl.led_off;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_soft_self_clear: assert property (wr_en && wr_data[phy_ctl_pkg::B_SOFT_RESET]
                                       |=> soft_reset && readback == phy_ctl_pkg::CTRL_RESET_VAL ##1 !soft_reset)
      else $error("soft reset did not reload defaults and clear");
   a_loop_follow: assert property (wr_en && !wr_data[phy_ctl_pkg::B_SOFT_RESET]
                                   |=> ctrl.mac_loopback == $past(wr_data[phy_ctl_pkg::B_LOOPBACK]))
      else $error("loopback bit not taken");
   a_speed_duplex: assert property (wr_en && !wr_data[phy_ctl_pkg::B_SOFT_RESET]
                                    |=> ctrl.speed_100 == $past(wr_data[phy_ctl_pkg::B_SPEED_100])
                                    && ctrl.full_duplex == $past(wr_data[phy_ctl_pkg::B_FULL_DUPLEX]))
      else $error("speed or duplex not taken");
   a_restart_pulse: assert property (restart |=> !restart && !readback[phy_ctl_pkg::B_NEG_RESTART])
      else $error("restart not a single pulse");
   a_pair_force: assert property (ctrl.pair_force_straight == (readback[phy_ctl_pkg::B_XDET_OFF]
                                  && readback[phy_ctl_pkg::B_STRAIGHT]) && ctrl.pair_force_crossed
                                  == (readback[phy_ctl_pkg::B_XDET_OFF] && !readback[phy_ctl_pkg::B_STRAIGHT]))
      else $error("pair force mismatch");
endmodule

// [verilog/phy_mgmt_regs.sv]
module phy_mgmt_regs #(
   parameter int NUM_PORTS = 5
) (
   // clock and reset
   input  wire logic                              ref_clk,
   input  wire logic                              rst,
   // serial management pins
   input  wire logic                              mdc,
   input  wire logic                              mdio_in,
   output logic                                   mdio_out,
   output logic                                   mdio_oe,
   // spi pins
   input  wire logic                              spi_sclk,
   input  wire logic                              spi_cs_n,
   input  wire logic                              spi_mosi,
   output logic                                   spi_miso,
   output logic                                   spi_miso_oe,
   // per-port control
   output phy_ctl_pkg::phy_ctrl_t [NUM_PORTS-1:0] port_ctrl,
   output logic [NUM_PORTS-1:0]                   port_soft_reset,
   output logic [NUM_PORTS-1:0]                   port_neg_restart
);

   localparam int PW = 3;

   phy_ctl_pkg::mgmt_state_t  st_ff;
   phy_ctl_pkg::mgmt_state_t  nxt_st;
   logic [NUM_PORTS-1:0][15:0] readback;
   logic                      mdc_rise;
   logic                      sck_rise;
   logic                      sck_fall;
   logic                      spi_sel;
   logic [11:0]               hdr_n;
   logic [15:0]               spi_hdr_n;
   logic                      mdio_port_ok;
   logic                      spi_port_ok;

   ////////////////////////////////////////////////////////////////////////////
   // per-port control registers
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      logic port_hit;
      // ports 3, 4 and 5 are addressed exactly like ports 1 and 2
      assign port_hit = st_ff.wr.valid && st_ff.wr.addr == phy_ctl_pkg::REG_CTRL
                        && st_ff.wr.port == PW'(p + 1);
      phy_ctrl_reg u_reg (
         .ref_clk    (ref_clk),
         .rst        (rst),
         .wr_en      (port_hit),
         .wr_data    (st_ff.wr.data),
         .ctrl       (port_ctrl[p]),
         .readback   (readback[p]),
         .soft_reset (port_soft_reset[p]),
         .restart    (port_neg_restart[p])
      );
   end

   // read value: only the control word lives here, others read zero
   function automatic logic [15:0] read_word(logic [PW-1:0] port, logic [4:0] addr);
      logic [15:0] v;
      v = '0;
      for (int i = 0; i < NUM_PORTS; i++) begin
         if (port == PW'(i + 1) && addr == phy_ctl_pkg::REG_CTRL) begin
            v = readback[i];
         end
      end
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // edge detection on synchronised pins
   assign mdc_rise  = st_ff.mdc_s2 & ~st_ff.mdc_s3;
   assign sck_rise  = st_ff.sck_s2 & ~st_ff.sck_s3;
   assign sck_fall  = ~st_ff.sck_s2 & st_ff.sck_s3;
   assign spi_sel   = ~st_ff.cs_s2;
   assign hdr_n     = {st_ff.hdr[10:0], st_ff.mdi_s2};
   assign spi_hdr_n = {st_ff.spi_hdr[14:0], st_ff.mosi_s2};
   // phy address selects the port; zero and unpopulated addresses stay silent on mdio and read as zero on spi
   assign mdio_port_ok = hdr_n[9:5] >= 5'h01 && hdr_n[9:5] <= 5'(NUM_PORTS);
   assign spi_port_ok  = spi_hdr_n[7:5] >= 3'h1 && spi_hdr_n[7:5] <= PW'(NUM_PORTS);

   ////////////////////////////////////////////////////////////////////////////
   // next state: synchronisers, serial management engine, spi engine
   always_comb begin
      nxt_st          = st_ff;
      nxt_st.mdc_s1   = mdc;
      nxt_st.mdc_s2   = st_ff.mdc_s1;
      nxt_st.mdc_s3   = st_ff.mdc_s2;
      nxt_st.mdi_s1   = mdio_in;
      nxt_st.mdi_s2   = st_ff.mdi_s1;
      nxt_st.sck_s1   = spi_sclk;
      nxt_st.sck_s2   = st_ff.sck_s1;
      nxt_st.sck_s3   = st_ff.sck_s2;
      nxt_st.cs_s1    = spi_cs_n;
      nxt_st.cs_s2    = st_ff.cs_s1;
      nxt_st.mosi_s1  = spi_mosi;
      nxt_st.mosi_s2  = st_ff.mosi_s1;
      nxt_st.wr.valid = 1'b0;

      // serial management frame, one bit per mdc rising edge
      if (mdc_rise) begin
         case (st_ff.ms)
            phy_ctl_pkg::MS_IDLE: begin
               if (st_ff.mdi_s2) begin
                  if (st_ff.pre_cnt < 6'(phy_ctl_pkg::PREAMBLE_BITS)) begin
                     nxt_st.pre_cnt = st_ff.pre_cnt + 6'h01;
                  end
               end else begin
                  if (st_ff.pre_cnt >= 6'(phy_ctl_pkg::PREAMBLE_BITS)) begin
                     nxt_st.ms = phy_ctl_pkg::MS_START;
                  end
                  nxt_st.pre_cnt = '0;
               end
            end
            phy_ctl_pkg::MS_START: begin
               nxt_st.bit_cnt = '0;
               nxt_st.ms      = st_ff.mdi_s2 ? phy_ctl_pkg::MS_HDR : phy_ctl_pkg::MS_IDLE;
            end
            phy_ctl_pkg::MS_HDR: begin
               nxt_st.hdr     = hdr_n;
               nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
               if (st_ff.bit_cnt == 5'(phy_ctl_pkg::HDR_BITS - 1)) begin
                  nxt_st.bit_cnt = '0;
                  nxt_st.ms      = phy_ctl_pkg::MS_SKIP;
                  // only supported addresses of a populated port are answered
                  if (mdio_port_ok && phy_ctl_pkg::reg_supported(hdr_n[4:0])) begin
                     if (hdr_n[11:10] == phy_ctl_pkg::MDIO_OP_RD) begin
                        nxt_st.ms    = phy_ctl_pkg::MS_TA_RD;
                        nxt_st.rdata = read_word(hdr_n[PW+4:5], hdr_n[4:0]);
                     end else if (hdr_n[11:10] == phy_ctl_pkg::MDIO_OP_WR) begin
                        nxt_st.ms = phy_ctl_pkg::MS_TA_WR;
                     end
                  end
               end
            end
            phy_ctl_pkg::MS_TA_RD: begin
               // first turnaround bit left to the station, second driven low
               nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
               if (st_ff.bit_cnt == '0) begin
                  nxt_st.mdio_oe  = 1'b1;
                  nxt_st.mdio_out = 1'b0;
               end else begin
                  nxt_st.mdio_out = st_ff.rdata[15];
                  nxt_st.rdata    = {st_ff.rdata[14:0], 1'b0};
                  nxt_st.bit_cnt  = '0;
                  nxt_st.ms       = phy_ctl_pkg::MS_DATA_RD;
               end
            end
            phy_ctl_pkg::MS_DATA_RD: begin
               nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
               if (st_ff.bit_cnt == 5'(phy_ctl_pkg::DATA_BITS - 1)) begin
                  nxt_st.mdio_oe  = 1'b0;
                  nxt_st.mdio_out = 1'b0;
                  nxt_st.ms       = phy_ctl_pkg::MS_IDLE;
               end else begin
                  nxt_st.mdio_out = st_ff.rdata[15];
                  nxt_st.rdata    = {st_ff.rdata[14:0], 1'b0};
               end
            end
            phy_ctl_pkg::MS_TA_WR: begin
               nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
               if (st_ff.bit_cnt == 5'(phy_ctl_pkg::TA_BITS - 1)) begin
                  nxt_st.bit_cnt = '0;
                  nxt_st.ms      = phy_ctl_pkg::MS_DATA_WR;
               end
            end
            phy_ctl_pkg::MS_DATA_WR: begin
               nxt_st.wdata   = {st_ff.wdata[14:0], st_ff.mdi_s2};
               nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
               if (st_ff.bit_cnt == 5'(phy_ctl_pkg::DATA_BITS - 1)) begin
                  nxt_st.wr.valid = 1'b1;
                  nxt_st.wr.port  = st_ff.hdr[PW+4:5];
                  nxt_st.wr.addr  = st_ff.hdr[4:0];
                  nxt_st.wr.data  = {st_ff.wdata[14:0], st_ff.mdi_s2};
                  nxt_st.ms       = phy_ctl_pkg::MS_IDLE;
               end
            end
            phy_ctl_pkg::MS_SKIP: begin
               // foreign frame: let turnaround and data pass unanswered
               nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
               if (st_ff.bit_cnt == 5'(phy_ctl_pkg::TA_BITS + phy_ctl_pkg::DATA_BITS - 1)) begin
                  nxt_st.ms = phy_ctl_pkg::MS_IDLE;
               end
            end
            default: begin
               nxt_st.ms      = phy_ctl_pkg::MS_IDLE;
               nxt_st.mdio_oe = 1'b0;
            end
         endcase
      end

      // spi frame: command, {port, reg} address byte, data word, msb first
      nxt_st.spi_oe = spi_sel;
      if (!spi_sel) begin
         nxt_st.spi_cnt  = '0;
         nxt_st.spi_miso = 1'b0;
      end else begin
         if (sck_rise && st_ff.spi_cnt < 6'(phy_ctl_pkg::SPI_FRAME)) begin
            nxt_st.spi_cnt = st_ff.spi_cnt + 6'h01;
            if (st_ff.spi_cnt < 6'(phy_ctl_pkg::SPI_HDR_BITS)) begin
               nxt_st.spi_hdr = spi_hdr_n;
            end else begin
               nxt_st.spi_wr = {st_ff.spi_wr[14:0], st_ff.mosi_s2};
            end
            // header complete: fetch read data
            if (st_ff.spi_cnt == 6'(phy_ctl_pkg::SPI_HDR_BITS - 1)) begin
               nxt_st.spi_rd = '0;
               if (spi_hdr_n[15:8] == phy_ctl_pkg::SPI_CMD_RD && spi_port_ok
                   && phy_ctl_pkg::reg_supported(spi_hdr_n[4:0])) begin
                  nxt_st.spi_rd = read_word(spi_hdr_n[7:5], spi_hdr_n[4:0]);
               end
            end
            // last data bit: commit a write to a supported address
            if (st_ff.spi_cnt == 6'(phy_ctl_pkg::SPI_FRAME - 1)
                && st_ff.spi_hdr[15:8] == phy_ctl_pkg::SPI_CMD_WR
                && st_ff.spi_hdr[7:5] >= 3'h1 && st_ff.spi_hdr[7:5] <= PW'(NUM_PORTS)
                && phy_ctl_pkg::reg_supported(st_ff.spi_hdr[4:0]) && !nxt_st.wr.valid) begin
               nxt_st.wr.valid = 1'b1;
               nxt_st.wr.port  = st_ff.spi_hdr[7:5];
               nxt_st.wr.addr  = st_ff.spi_hdr[4:0];
               nxt_st.wr.data  = {st_ff.spi_wr[14:0], st_ff.mosi_s2};
            end
         end
         // data phase of a read: shift out on falling edges
         if (sck_fall && st_ff.spi_cnt >= 6'(phy_ctl_pkg::SPI_HDR_BITS)
             && st_ff.spi_cnt < 6'(phy_ctl_pkg::SPI_FRAME)) begin
            nxt_st.spi_miso = st_ff.spi_rd[15];
            nxt_st.spi_rd   = {st_ff.spi_rd[14:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_ff    <= '0;
         st_ff.ms <= phy_ctl_pkg::MS_IDLE;
         // select synchronisers start at the deselected level: no false select after reset
         st_ff.cs_s1 <= 1'b1;
         st_ff.cs_s2 <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign mdio_out    = st_ff.mdio_out;
   assign mdio_oe     = st_ff.mdio_oe;
   assign spi_miso    = st_ff.spi_miso;
   assign spi_miso_oe = st_ff.spi_oe;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_write_port_range: assert property (st_ff.wr.valid
                                        |-> st_ff.wr.port >= 3'h1 && st_ff.wr.port <= PW'(NUM_PORTS))
      else $error("write to unpopulated port");
   a_write_addr_ok: assert property (st_ff.wr.valid |-> phy_ctl_pkg::reg_supported(st_ff.wr.addr))
      else $error("write to unsupported register");
   a_ta_drive_low: assert property ($rose(mdio_oe) |-> !mdio_out && st_ff.ms == phy_ctl_pkg::MS_TA_RD)
      else $error("turnaround not driven low");
   a_idle_released: assert property (st_ff.ms == phy_ctl_pkg::MS_IDLE |-> !mdio_oe)
      else $error("mdio driven outside a read");
   a_spi_release: assert property (st_ff.cs_s2 |=> !spi_miso_oe)
      else $error("miso driven while deselected");
   a_ctrl_write_lands: assert property (st_ff.wr.valid && st_ff.wr.addr == phy_ctl_pkg::REG_CTRL
                                        && st_ff.wr.port == 3'h3 && !st_ff.wr.data[phy_ctl_pkg::B_SOFT_RESET]
                                        |=> port_ctrl[2].mac_loopback == $past(st_ff.wr.data[phy_ctl_pkg::B_LOOPBACK]))
      else $error("port 3 loopback write lost");
   c_mdio_read: cover property ($fell(mdio_oe));
   c_mdio_write: cover property (st_ff.wr.valid && st_ff.ms == phy_ctl_pkg::MS_IDLE && !spi_sel);
   c_spi_write: cover property (st_ff.wr.valid && spi_sel);
endmodule

// [sim/mgmt_host.sv]
module mgmt_host (
   // clock
   input  wire logic ref_clk,
   // serial management side
   output logic      mdc,
   output wire logic mdio_in,
   input  wire logic mdio_out,
   input  wire logic mdio_oe,
   // spi side
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_mosi,
   input  wire logic spi_miso,
   input  wire logic spi_miso_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic host_bit = 1'b1;
   logic host_oe  = 1'b0;
   initial {mdc, spi_sclk, spi_cs_n, spi_mosi} = 4'b0010;
   // wire level: device drive, else host drive, else pull-up
   assign mdio_in = mdio_oe ? mdio_out : (host_oe ? host_bit : 1'b1);
   wire logic miso_line;
   // released miso shows the inverse of the last bit, so an undriven read cannot pass
   assign miso_line = spi_miso_oe ? spi_miso : ~spi_miso;
   // one management frame, host lets go of the wire from turnaround on reads
   task automatic mdio_frame(input logic rd, input logic [4:0] phy, ra, input logic [15:0] wd, output logic [15:0] q);
      logic [63:0] f;
      f = {32'hffff_ffff, 2'b01, rd ? 2'b10 : 2'b01, phy, ra, 2'b10, wd};
      for (int i = 63; i >= 0; i--) begin
         @(negedge ref_clk);
         mdc      = 1'b0;
         host_bit = f[i];
         host_oe  = !rd || i > 17;
         repeat (4) @(negedge ref_clk);
         if (i < 16) q = {q[14:0], mdio_in};
         mdc = 1'b1;
         repeat (5) @(negedge ref_clk);
      end
      host_oe = 1'b0;
   endtask
   // one 32-bit spi frame on port address, register 0
   task automatic spi_frame(input logic [7:0] cmd, input logic [2:0] port, input logic [15:0] wd,
                            output logic [15:0] q);
      logic [31:0] f;
      f = {cmd, port, 5'h00, wd};
      @(negedge ref_clk);
      spi_cs_n = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         @(negedge ref_clk);
         spi_sclk = 1'b0;
         spi_mosi = f[i];
         repeat (4) @(negedge ref_clk);
         if (i < 16) q = {q[14:0], miso_line};
         spi_sclk = 1'b1;
         repeat (5) @(negedge ref_clk);
      end
      spi_sclk = 1'b0;
      repeat (4) @(negedge ref_clk);
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
   endtask
endmodule

// [sim/phy_basic_control_register_tb.sv]
`define CHK(n, e, s) begin \
   checked++; \
   if ((e) !== (s)) begin \
      failures++; \
      $display("wrong value %s expected %h seen %h", n, e, s); \
   end \
end
module phy_basic_control_register_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   wire logic mdc, mdio_in, mdio_out, mdio_oe, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   phy_ctl_pkg::phy_ctrl_t [4:0] port_ctrl;
   logic [4:0]  port_soft_reset, port_neg_restart;
   logic [4:0]  seen_rst = '0, seen_rs = '0, exp_rst = '0, exp_rs = '0;
   logic [15:0] shadow [5];
   logic [15:0] q, d;
   int          failures = 0, checked = 0, cycles = 0, p;
   int          seed = 32'h807b;
   always #12.5 ref_clk = ~ref_clk;
   phy_mgmt_regs phy_mgmt_regs_i (.ref_clk(ref_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
      .mdio_oe(mdio_oe), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .port_ctrl(port_ctrl), .port_soft_reset(port_soft_reset),
      .port_neg_restart(port_neg_restart));
   mgmt_host mgmt_host_i (.ref_clk(ref_clk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe));
   // sticky pulse record and hang watchdog, sampled mid-cycle where pulses are settled
   always @(negedge ref_clk) begin
      seen_rst <= seen_rst | port_soft_reset;
      seen_rs  <= seen_rs | port_neg_restart;
      cycles   <= cycles + 1;
      if (cycles == 40000) begin
         failures++;
         end_of_test();
      end
   end
   // control fields expected from a stored word
   function automatic phy_ctl_pkg::phy_ctrl_t exp_ctrl(input logic [15:0] w);
      return {w[14:10], w[8], w[5:0], w[3] & w[4], w[3] & ~w[4]};
   endfunction
   task automatic check_all();
      phy_ctl_pkg::phy_ctrl_t e;
      for (int k = 0; k < 5; k++) begin
         e = exp_ctrl(shadow[k]);
         `CHK("link fields", e[13:8], port_ctrl[k][13:8])
         `CHK("pair and port fields", e[7:0], port_ctrl[k][7:0])
      end
   endtask
   task end_of_test();
      if (failures == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge ref_clk);
      rst = 1'b0;
      repeat (2) @(negedge ref_clk);
      `CHK("miso enable after reset", 1'b0, spi_miso_oe)
      `CHK("mdio enable after reset", 1'b0, mdio_oe)
      repeat (2) @(negedge ref_clk);
      for (int k = 0; k < 5; k++) shadow[k] = 16'h3120;
      check_all();
      // random writes on one bus, read back on the other
      for (int n = 0; n < 12; n++) begin
         p = $unsigned($random(seed)) % 5;
         d = $random(seed) & 16'h7fff;
         shadow[p] = d & 16'h7d3f;
         exp_rs[p] |= d[9];
         if (n % 2) mgmt_host_i.mdio_frame(1'b0, 5'(p + 1), 5'h00, d, q);
         else mgmt_host_i.spi_frame(8'h02, 3'(p + 1), d, q);
         repeat (4) @(negedge ref_clk);
         check_all();
         if (n % 2) mgmt_host_i.spi_frame(8'h03, 3'(p + 1), 16'h0000, q);
         else mgmt_host_i.mdio_frame(1'b1, 5'(p + 1), 5'h00, 16'h0000, q);
         `CHK("readback", shadow[p], q)
      end
      // writes to absent addresses change nothing
      mgmt_host_i.mdio_frame(1'b0, 5'h00, 5'h00, 16'hffff, q);
      mgmt_host_i.mdio_frame(1'b0, 5'h01, 5'h06, 16'hffff, q);
      repeat (4) @(negedge ref_clk);
      check_all();
      mgmt_host_i.mdio_frame(1'b1, 5'h01, 5'h06, 16'h0000, q);
      `CHK("undriven read", 16'hffff, q)
      mgmt_host_i.mdio_frame(1'b1, 5'h04, 5'h1d, 16'h0000, q);
      `CHK("answered read", 16'h0000, q)
      // soft reset returns port 3 to defaults and self-clears
      mgmt_host_i.mdio_frame(1'b0, 5'h03, 5'h00, 16'hc000, q);
      shadow[2] = 16'h3120;
      exp_rst[2] = 1'b1;
      repeat (4) @(negedge ref_clk);
      check_all();
      `CHK("soft reset pulse", exp_rst, seen_rst)
      `CHK("restart pulse", exp_rs, seen_rs)
      mgmt_host_i.spi_frame(8'h03, 3'h3, 16'h0000, q);
      `CHK("reset readback", 16'h3120, q)
      end_of_test();
   end
endmodule
